/* rtl/fadrv_axis_step.sv */
`timescale 1ns/1ps
module fadrv_axis_step #(
  parameter int TRAVEL_W = fadrv_pkg::TRAVEL_W,
  parameter int VEL_W = fadrv_pkg::ACC_W
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic run,
  input wire logic start,
  input wire logic [TRAVEL_W-1:0] travel,
  input wire logic [VEL_W-1:0] vel,
  input wire logic ccw,
  output logic step_q,
  output logic dir_q,
  output logic busy_q
);

  logic [VEL_W-1:0] acc_q;
  logic pend_q;
  logic [fadrv_pkg::CNT_W-1:0] gap_q;
  logic [fadrv_pkg::CNT_W-1:0] hi_q;
  logic [TRAVEL_W-1:0] remain_q;
  logic [VEL_W:0] sum;
  logic accept;
  logic fire;

  function automatic logic [VEL_W-1:0] clamp_vel(input logic [VEL_W-1:0] v);
    return (v > VEL_W'(fadrv_pkg::VEL_MAX)) ? VEL_W'(fadrv_pkg::VEL_MAX) : v;
  endfunction

  assign accept = start & run & ~busy_q & (remain_q == '0) & (travel != '0);
  assign sum = {1'b0, acc_q} + {1'b0, clamp_vel(vel)};
  // Min gap holds a carry back, so the rate is capped, not wrapped
  assign fire = busy_q & run & pend_q & (gap_q == fadrv_pkg::CNT_ZERO) & ~step_q & (remain_q != '0);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= '0;
      pend_q <= 1'b0;
    end else if (accept || !busy_q) begin
      acc_q <= '0;
      pend_q <= 1'b0;
    end else begin
      acc_q <= sum[VEL_W-1:0];
      pend_q <= sum[VEL_W] | (pend_q & ~fire);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_q <= fadrv_pkg::CNT_ZERO;
    end else if (accept || fire) begin
      gap_q <= fadrv_pkg::GAP_RELOAD;
    end else if (gap_q != fadrv_pkg::CNT_ZERO) begin
      gap_q <= gap_q - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      step_q <= 1'b0;
      hi_q <= fadrv_pkg::CNT_ZERO;
    end else if (!run) begin
      step_q <= 1'b0;
      hi_q <= fadrv_pkg::CNT_ZERO;
    end else if (fire) begin
      step_q <= 1'b1;
      hi_q <= fadrv_pkg::HIGH_RELOAD;
    end else if (hi_q != fadrv_pkg::CNT_ZERO) begin
      hi_q <= hi_q - 8'h01;
    end else begin
      step_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      remain_q <= '0;
      busy_q <= 1'b0;
      dir_q <= 1'b0;
    end else if (!run) begin
      remain_q <= '0;
      busy_q <= 1'b0;
    end else if (accept) begin
      remain_q <= travel;
      busy_q <= 1'b1;
      dir_q <= ccw;
    end else begin
      if (fire) begin
        remain_q <= remain_q - TRAVEL_W'(1);
      end
      if (remain_q == '0 && !step_q) begin
        busy_q <= 1'b0;
      end
    end
  end

  logic [fadrv_pkg::CNT_W-1:0] since_q;
  logic [TRAVEL_W-1:0] issued_q;
  logic [TRAVEL_W-1:0] goal_q;
  logic step_prev_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      since_q <= fadrv_pkg::GAP_RELOAD;
      issued_q <= '0;
      goal_q <= '0;
      step_prev_q <= 1'b0;
    end else begin
      step_prev_q <= step_q;
      if (step_q && !step_prev_q) begin
        since_q <= fadrv_pkg::CNT_ZERO;
      end else if (since_q != fadrv_pkg::GAP_RELOAD) begin
        since_q <= since_q + 8'h01;
      end
      if (accept) begin
        issued_q <= '0;
        goal_q <= travel;
      end else if (step_q && !step_prev_q) begin
        issued_q <= issued_q + TRAVEL_W'(1);
      end
    end
  end

  a_step_spacing: assert property (@(posedge clk) disable iff (!arst_n)
    (step_q && !step_prev_q) |-> (since_q == fadrv_pkg::GAP_RELOAD))
    else $error("Step edges closer than minimum period");

  a_dir_stable: assert property (@(posedge clk) disable iff (!arst_n)
    (step_q || $rose(step_q)) |-> $stable(dir_q))
    else $error("Direction changed while step high");

  a_ccw_sense: assert property (@(posedge clk) disable iff (!arst_n)
    accept |=> (dir_q == $past(ccw)) ##1 (!step_q))
    else $error("Direction not taken from command");

  a_travel_count: assert property (@(posedge clk) disable iff (!arst_n)
    ($fell(busy_q) && $past(run)) |-> (issued_q == goal_q))
    else $error("Step count differs from travel");

  c_move_done: cover property (@(posedge clk) disable iff (!arst_n)
    $fell(busy_q) && run && (goal_q > TRAVEL_W'(2)));

  c_dir_change: cover property (@(posedge clk) disable iff (!arst_n)
    accept && (ccw != dir_q));

endmodule

/* rtl/fadrv_pkg.sv */
package fadrv_pkg;

  localparam int NUM_AXES = 4;
  localparam int CLK_HZ = 40_000_000;
  localparam int STEP_FMAX_HZ = 750_000;
  // Shortest step period, rounded up so the rate never exceeds the limit
  localparam int STEP_MIN_PERIOD_CYC = (CLK_HZ + STEP_FMAX_HZ - 1) / STEP_FMAX_HZ;
  localparam int STEP_HIGH_CYC = STEP_MIN_PERIOD_CYC / 2;
  localparam int CNT_W = 8;
  localparam int TRAVEL_W = 32;
  localparam int ACC_W = 24;
  localparam int SETPOINT_W = 16;
  // Velocity word for the top step rate, rounded down so it never exceeds that rate
  localparam logic [ACC_W-1:0] VEL_MAX =
    ACC_W'((longint'(STEP_FMAX_HZ) << ACC_W) / longint'(CLK_HZ));
  localparam logic [CNT_W-1:0] GAP_RELOAD = CNT_W'(STEP_MIN_PERIOD_CYC - 1);
  localparam logic [CNT_W-1:0] HIGH_RELOAD = CNT_W'(STEP_HIGH_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  typedef enum logic {
    FADRV_ANALOG = 1'b0,
    FADRV_STEPPER = 1'b1
  } fadrv_drive_t;

endpackage

/* rtl/fadrv_top.sv */
`timescale 1ns/1ps
// What this block does
// - Step, direction, enable each true and complemented
// - Step count equals commanded travel
// - Rate follows velocity, capped at 750 kHz
// - Direction high means counterclockwise
// - Enable active once closed-loop control starts
// - Enable output and relay change together
// - Analog axis: setpoint plus enable contact
// - Fixed mapping of signal groups to axes
// - Each axis runs by its own type
// - Any analog/stepper mix over four axes
module fadrv_top #(
  parameter int NUM_AXES = fadrv_pkg::NUM_AXES,
  parameter int TRAVEL_W = fadrv_pkg::TRAVEL_W,
  parameter int VEL_W = fadrv_pkg::ACC_W,
  parameter int SETPOINT_W = fadrv_pkg::SETPOINT_W
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic [NUM_AXES-1:0] drive_type,
  input wire logic [NUM_AXES-1:0] loop_active,
  input wire logic [NUM_AXES-1:0] move_start,
  input wire logic [NUM_AXES*TRAVEL_W-1:0] move_travel,
  input wire logic [NUM_AXES*VEL_W-1:0] move_velocity,
  input wire logic [NUM_AXES-1:0] move_ccw,
  input wire logic [NUM_AXES*SETPOINT_W-1:0] analog_setpoint,
  output logic [NUM_AXES-1:0] step_strobe,
  output logic [NUM_AXES-1:0] step_strobe_inverted,
  output logic [NUM_AXES-1:0] rotation_sense,
  output logic [NUM_AXES-1:0] rotation_sense_inverted,
  output logic [NUM_AXES-1:0] power_enable,
  output logic [NUM_AXES-1:0] power_enable_inverted,
  output logic [NUM_AXES-1:0] drive_release_contact,
  output logic [NUM_AXES*SETPOINT_W-1:0] speed_setpoint,
  output logic [NUM_AXES-1:0] move_busy
);

  logic [NUM_AXES-1:0] step_int;
  logic [NUM_AXES-1:0] dir_int;
  logic [NUM_AXES-1:0] busy_int;
  logic [NUM_AXES-1:0] is_step;

  function automatic logic is_stepper(input logic t);
    return t == fadrv_pkg::FADRV_STEPPER;
  endfunction

  // Each index is one axis; no crossbar, so axis n always owns group n
  for (genvar i = 0; i < NUM_AXES; i++) begin : g_axis
    assign is_step[i] = is_stepper(drive_type[i]);

    fadrv_axis_step #(
      .TRAVEL_W(TRAVEL_W),
      .VEL_W(VEL_W)
    ) u_step (
      .clk(mclk),
      .arst_n(arst_n),
      .run(is_step[i] & loop_active[i]),
      .start(move_start[i]),
      .travel(move_travel[i*TRAVEL_W +: TRAVEL_W]),
      .vel(move_velocity[i*VEL_W +: VEL_W]),
      .ccw(move_ccw[i]),
      .step_q(step_int[i]),
      .dir_q(dir_int[i]),
      .busy_q(busy_int[i])
    );
  end

  // True and inverted lines loaded on the same edge, no skew between them
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      step_strobe <= '0;
      step_strobe_inverted <= '1;
      rotation_sense <= '0;
      rotation_sense_inverted <= '1;
      move_busy <= '0;
    end else begin
      step_strobe <= step_int & is_step;
      step_strobe_inverted <= ~(step_int & is_step);
      rotation_sense <= dir_int & is_step;
      rotation_sense_inverted <= ~(dir_int & is_step);
      move_busy <= busy_int;
    end
  end

  // Enable, its complement and the relay share one source and one edge
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      power_enable <= '0;
      power_enable_inverted <= '1;
      drive_release_contact <= '0;
    end else begin
      power_enable <= loop_active;
      power_enable_inverted <= ~loop_active;
      drive_release_contact <= loop_active;
    end
  end

  // Setpoint forced to zero unless an enabled analog axis
  for (genvar i = 0; i < NUM_AXES; i++) begin : g_sp
    always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
        speed_setpoint[i*SETPOINT_W +: SETPOINT_W] <= '0;
      end else if (!is_step[i] && loop_active[i]) begin
        speed_setpoint[i*SETPOINT_W +: SETPOINT_W] <= analog_setpoint[i*SETPOINT_W +: SETPOINT_W];
      end else begin
        speed_setpoint[i*SETPOINT_W +: SETPOINT_W] <= '0;
      end
    end

    a_enable_follow: assert property (@(posedge mclk) disable iff (!arst_n)
      ##1 (power_enable[i] == $past(loop_active[i])))
      else $error("Enable does not follow loop state");

    a_enable_relay_same: assert property (@(posedge mclk) disable iff (!arst_n)
      (power_enable[i] == drive_release_contact[i]) && (power_enable_inverted[i] != power_enable[i]))
      else $error("Enable and relay differ");

    a_step_pair: assert property (@(posedge mclk) disable iff (!arst_n)
      (step_strobe[i] != step_strobe_inverted[i]) && (rotation_sense[i] != rotation_sense_inverted[i]))
      else $error("True and inverted lines equal");

    a_analog_quiet: assert property (@(posedge mclk) disable iff (!arst_n)
      (!is_step[i]) [*2] |-> !step_strobe[i] && !rotation_sense[i])
      else $error("Analog axis shows step activity");

    a_setpoint_gate: assert property (@(posedge mclk) disable iff (!arst_n)
      (!loop_active[i] || is_step[i]) |=> (speed_setpoint[i*SETPOINT_W +: SETPOINT_W] == '0))
      else $error("Setpoint present on disabled or stepper axis");

    c_analog_run: cover property (@(posedge mclk) disable iff (!arst_n)
      drive_release_contact[i] && (speed_setpoint[i*SETPOINT_W +: SETPOINT_W] != '0));

    c_mixed_axes: cover property (@(posedge mclk) disable iff (!arst_n)
      step_strobe[i] && (drive_type != '0) && (drive_type != '1));
  end

endmodule

/* tb/fadrv_drive_model.sv */
`timescale 1ns/1ps
module fadrv_drive_model #(
  parameter bit FALL = 1'b0
) (
  input wire logic step,
  input wire logic dir,
  input wire logic en,
  output int pos
);
  initial pos = 0;
  // One step per active edge, none while unpowered
  always @(step) begin
    if ((step ^ FALL) === 1'b1 && en === 1'b1) begin
      pos <= pos + (dir ? 1 : -1);
    end
  end
endmodule

/* tb/fadrv_top_tb_top.sv */
`timescale 1ns/1ps
module fadrv_top_tb_top;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] drive_type = 4'hf;
  logic [3:0] loop_active = 4'h0;
  logic [3:0] move_start = 4'h0;
  logic [127:0] move_travel = '0;
  logic [95:0] move_velocity = '0;
  logic [3:0] move_ccw = 4'h0;
  logic [63:0] analog_setpoint = '0;
  logic [3:0] step_strobe, step_strobe_inverted, rotation_sense, rotation_sense_inverted;
  logic [3:0] power_enable, power_enable_inverted, drive_release_contact, move_busy;
  logic [63:0] speed_setpoint;
  logic [3:0] pstep = 4'h0;
  logic [3:0] pdir = 4'h0;
  int bad_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rises, other, gmin, gmax, last, pos_a, pos_b;
  int wax = 0;
  always #12.5 mclk = ~mclk;
  fadrv_top uut (.mclk(mclk), .arst_n(arst_n), .drive_type(drive_type), .loop_active(loop_active),
    .move_start(move_start), .move_travel(move_travel), .move_velocity(move_velocity),
    .move_ccw(move_ccw), .analog_setpoint(analog_setpoint), .step_strobe(step_strobe),
    .step_strobe_inverted(step_strobe_inverted), .rotation_sense(rotation_sense),
    .rotation_sense_inverted(rotation_sense_inverted), .power_enable(power_enable),
    .power_enable_inverted(power_enable_inverted), .drive_release_contact(drive_release_contact),
    .speed_setpoint(speed_setpoint), .move_busy(move_busy));
  fadrv_drive_model drv_a (.step(step_strobe[0]), .dir(rotation_sense[0]), .en(power_enable[0]), .pos(pos_a));
  // Falling-edge drive on the complemented line
  fadrv_drive_model #(.FALL(1'b1)) drv_b (.step(step_strobe_inverted[0]), .dir(rotation_sense[0]),
    .en(power_enable[0]), .pos(pos_b));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (arst_n) begin
      chk("complements", {~step_strobe, ~rotation_sense, ~power_enable},
        {step_strobe_inverted, rotation_sense_inverted, power_enable_inverted});
      chk("relay", power_enable, drive_release_contact);
      chk("dir in high", 0, (rotation_sense ^ pdir) & step_strobe & pstep);
    end
    if (step_strobe[wax] && !pstep[wax]) begin
      rises++;
      if (last > 0 && cyc - last < gmin) gmin = cyc - last;
      if (last > 0 && cyc - last > gmax) gmax = cyc - last;
      last = cyc;
    end
    if ((step_strobe & ~pstep & ~(4'h1 << wax)) != 4'h0) other++;
    pstep = step_strobe;
    pdir = rotation_sense;
    // Ceiling well above the longest expected run
    if (cyc == 20000) begin
      bad_count++;
      final_report();
    end
  end
  task t_reset;
    chk("step", 0, step_strobe);
    chk("enable", 0, power_enable);
    chk("setpoint", 0, speed_setpoint[31:0]);
    chk("busy", 0, move_busy);
    $display("test reset done");
  endtask
  task t_enable;
    @(posedge mclk) loop_active <= 4'h5;
    #1;
    chk("enable early", 0, power_enable);
    @(posedge mclk) #1;
    chk("enable", 4'h5, power_enable);
    chk("contact", 4'h5, drive_release_contact);
    @(posedge mclk) loop_active <= 4'hf;
    repeat (2) @(posedge mclk);
    $display("test enable done");
  endtask
  task automatic t_move(input int ax, input int n, input logic ccw, input logic [23:0] v, input int lo,
      input int hi);
    int p0 = pos_a;
    int k = 0;
    wax = ax;
    rises = 0;
    other = 0;
    last = 0;
    gmin = 100000;
    gmax = 0;
    @(posedge mclk);
    move_start[ax] <= 1'b1;
    move_travel[ax*32 +: 32] <= n;
    move_velocity[ax*24 +: 24] <= v;
    move_ccw[ax] <= ccw;
    @(posedge mclk) move_start[ax] <= 1'b0;
    while (move_busy[ax] !== 1'b1 && k < 10) begin
      @(posedge mclk) k++;
    end
    while (move_busy[ax] === 1'b1 && k < 8000) begin
      @(posedge mclk) k++;
    end
    chk("step count", n, rises);
    chk("rotation", ccw, rotation_sense[ax]);
    chk("step spacing", 1, gmin >= lo && gmax <= hi);
    chk("other axes", 0, other);
    if (ax == 0) begin
      chk("drive position", ccw ? n : -n, pos_a - p0);
      chk("falling drive", pos_a, pos_b);
    end
    $display("test move axis %0d done", ax);
  endtask
  task t_abort;
    @(posedge mclk);
    move_start[1] <= 1'b1;
    move_travel[63:32] <= 100;
    move_velocity[47:24] <= fadrv_pkg::VEL_MAX;
    @(posedge mclk) move_start[1] <= 1'b0;
    repeat (150) @(posedge mclk);
    loop_active[1] <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk("abort step", 0, step_strobe[1]);
    chk("abort enable", 0, {power_enable[1], drive_release_contact[1]});
    chk("abort busy", 0, move_busy[1]);
    @(posedge mclk) move_start[1] <= 1'b1;
    @(posedge mclk) move_start[1] <= 1'b0;
    repeat (4) @(posedge mclk);
    chk("refused start", 0, move_busy[1]);
    loop_active[1] <= 1'b1;
    $display("test abort done");
  endtask
  task t_analog;
    @(posedge mclk);
    drive_type <= 4'h7;
    analog_setpoint[63:48] <= 16'h1234;
    move_start[3] <= 1'b1;
    @(posedge mclk) move_start[3] <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    chk("setpoint", 16'h1234, speed_setpoint[63:48]);
    chk("stepper setpoints", 0, speed_setpoint[47:16]);
    chk("analog stepper lines", 0, {step_strobe[3], rotation_sense[3], move_busy[3]});
    chk("analog contact", 1, drive_release_contact[3]);
    t_move(0, 2, 1'b1, fadrv_pkg::VEL_MAX, 54, 60);
    @(posedge mclk) loop_active[3] <= 1'b0;
    repeat (3) @(posedge mclk);
    chk("setpoint off", 0, speed_setpoint[63:48]);
    $display("test analog done");
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk) #1;
    t_reset();
    t_enable();
    t_move(0, 3, 1'b1, fadrv_pkg::VEL_MAX, 54, 60);
    t_move(0, 2, 1'b0, fadrv_pkg::VEL_MAX >> 1, 100, 112);
    t_move(2, 4, 1'b1, 24'hffffff, 54, 60);
    t_abort();
    t_analog();
    final_report();
  end
endmodule
